/* design/drsup_regs.svh */
`ifndef DRSUP_REGS_SVH
`define DRSUP_REGS_SVH
// register byte offsets
`define DRSUP_ADR_LIMITS 8'h00
`define DRSUP_ADR_CONFIG 8'h04
`define DRSUP_ADR_SERIAL 8'h08
`define DRSUP_ADR_JOG 8'h0C
`define DRSUP_ADR_PRESET1 8'h10
`define DRSUP_ADR_RIDE 8'h14
`define DRSUP_ADR_STATUS 8'h18
`define DRSUP_ADR_OUTFREQ 8'h1C
`define DRSUP_ADR_MAXFREQ 8'h20
// reset values and write limits
`define DRSUP_UPPER_RST 7'h64
`define DRSUP_LOWER_RST 7'h00
`define DRSUP_UPPER_MAX 7'h6D
`define DRSUP_LOWER_MAX 7'h64
`define DRSUP_JOG_RST 12'h03C
`define DRSUP_JOG_MAX 12'hFA0
`define DRSUP_MAXF_RST 12'h258
`define DRSUP_OPMODE_RST 4'h3
`define DRSUP_BAUD_RST 2'h2
`define DRSUP_PARITY_RST 2'h1
`define DRSUP_TOEN_RST 1'h1
`define DRSUP_RESP_RST 2'h1
`define DRSUP_RIDE_T_RST 5'h14
`define DRSUP_RIDE_T_MAX 5'h14
// timing
`define DRSUP_CLK_HZ 50000000
`define DRSUP_LOSS_MS 400
`define DRSUP_TIMEOUT_MS 2000
`define DRSUP_RIDE_MAX_MS 2000
`define DRSUP_RIDE_STEP_MS 100
`define DRSUP_LOSS_CYC (`DRSUP_CLK_HZ / 1000 * `DRSUP_LOSS_MS)
`define DRSUP_TIMEOUT_CYC (`DRSUP_CLK_HZ / 1000 * `DRSUP_TIMEOUT_MS)
`define DRSUP_RIDE_STEP_CYC (`DRSUP_CLK_HZ / 1000 * `DRSUP_RIDE_STEP_MS)
`define DRSUP_RIDE_MAX_CYC (`DRSUP_CLK_HZ / 1000 * `DRSUP_RIDE_MAX_MS)
`endif

/* design/drsup_pkg.sv */
package drsup_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } drsup_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } drsup_wb_rsp_t;
  typedef struct packed {
    logic run;
    logic jog;
    logic serial_sel;
    logic updown_hold;
    logic power_loss;
  } drsup_term_t;
  typedef struct packed {
    logic cmd_valid;
    logic run;
    logic [15:0] freq;
  } drsup_serial_cmd_t;
  typedef struct packed {
    logic run;
    logic coast;
    logic decel2;
    logic fault;
    logic comm_alarm;
    logic undervoltage_alarm;
    logic [11:0] freq;
  } drsup_drive_t;
  typedef enum logic [2:0] {
    DRSUP_LOSS_IDLE = 3'b001,
    DRSUP_LOSS_WATCH = 3'b010,
    DRSUP_LOSS_HOLD = 3'b100
  } drsup_loss_t;
endpackage

/* design/drsup_top.sv */
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "drsup_regs.svh"
// Summary of operation
// - upper limit 0..109 percent, lower 0..100 percent, 1 percent steps.
// - every reference is clamped between lower and upper limit.
// - loss supervision active only with enable set; off after reset.
// - slow 90 percent drop: follow reference with normal deceleration.
// - fast 90 percent drop under 0.4 s: hold 80 percent of output.
// - hold ends when reference exceeds hold level or on stop.
// - no supervision while auto reference below 5 percent of maximum.
// - retention set: held reference stored into preset one.
// - jog with run ramps to jog reference, overriding operation mode; in serial mode run still comes from the serial command.
// - master starts each transaction; addressed slave executes then replies.
// - serial characters carry eight data bits and one stop bit.
// - baud select 0/1/2 gives 2400/4800/9600; master matches.
// - parity select 0 none, 1 even, 2 odd; master matches.
// - operation mode 4..8 takes run and reference from serial.
// - serial select input changes are ignored until drive stops.
// - serial reference rounded to 0.1 Hz, dropping hundredths.
// - timeout enabled: over 2.0 s between messages is an error.
// - error response 0 decel1, 1 coast, 2 decel2, each with fault; 3 alarm.
// - ride-through 0 stop, 1 up to 2 s, 2 indefinite.
// - stop when loss outlasts deactivation time 0.0..2.0 s, 0.1 s steps.
// - run held during ride-through; indefinite shows alarm, no fault.
module drsup_top #(
  parameter int LOSS_CYC = `DRSUP_LOSS_CYC,
  parameter int TIMEOUT_CYC = `DRSUP_TIMEOUT_CYC,
  parameter int RIDE_STEP_CYC = `DRSUP_RIDE_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire drsup_pkg::drsup_wb_req_t wb_req_i,
  output drsup_pkg::drsup_wb_rsp_t wb_rsp_o,
  input wire drsup_pkg::drsup_term_t term_i,
  input wire logic [11:0] auto_ref_i,
  input wire drsup_pkg::drsup_serial_cmd_t serial_cmd_i,
  output drsup_pkg::drsup_drive_t drive_o,
  output logic [4:0] serial_station_address_o,
  output logic [1:0] serial_baud_select_o,
  output logic [1:0] serial_parity_select_o
);
  import drsup_pkg::*;

  // settings written by software
  logic [6:0] ref_upper_limit_q, ref_lower_limit_q;
  logic [11:0] max_output_frequency_q, jog_reference_q;
  logic [11:0] preset_reference_one_q;
  logic ref_loss_detect_enable_q, held_ref_retention_q;
  logic [3:0] operation_mode_select_q;
  logic [1:0] serial_freq_resolution_q, comm_error_response_q;
  logic [4:0] station_q;
  logic [1:0] baud_q, parity_q;
  logic [4:0] station_act_q;
  logic [1:0] baud_act_q, parity_act_q;
  logic serial_timeout_enable_q;
  logic [1:0] ride_through_select_q;
  logic [4:0] ride_through_deactivation_time_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic err_clr;

  // terminal synchronisers
  drsup_term_t term_s1_q, term_s2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_s1_q <= '0;
      term_s2_q <= '0;
    end else begin
      term_s1_q <= term_i;
      term_s2_q <= term_s1_q;
    end
  end

  wire logic wb_hit = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire logic wb_wr = wb_hit & wb_req_i.we & (&wb_req_i.sel);
  assign err_clr = wb_wr && wb_req_i.adr == `DRSUP_ADR_STATUS;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_upper_limit_q <= `DRSUP_UPPER_RST;
      ref_lower_limit_q <= `DRSUP_LOWER_RST;
      max_output_frequency_q <= `DRSUP_MAXF_RST;
      jog_reference_q <= `DRSUP_JOG_RST;
      ref_loss_detect_enable_q <= 1'b0;
      held_ref_retention_q <= 1'b0;
      operation_mode_select_q <= `DRSUP_OPMODE_RST;
      serial_freq_resolution_q <= 2'h0;
      comm_error_response_q <= `DRSUP_RESP_RST;
      station_q <= 5'h00;
      baud_q <= `DRSUP_BAUD_RST;
      parity_q <= `DRSUP_PARITY_RST;
      serial_timeout_enable_q <= `DRSUP_TOEN_RST;
      ride_through_select_q <= 2'h0;
      ride_through_deactivation_time_q <= `DRSUP_RIDE_T_RST;
    end else if (wb_wr) begin
      case (wb_req_i.adr)
        `DRSUP_ADR_LIMITS: begin
          if (wb_req_i.dat[6:0] <= `DRSUP_UPPER_MAX) begin
            ref_upper_limit_q <= wb_req_i.dat[6:0];
          end
          if (wb_req_i.dat[14:8] <= `DRSUP_LOWER_MAX) begin
            ref_lower_limit_q <= wb_req_i.dat[14:8];
          end
        end
        `DRSUP_ADR_CONFIG: begin
          ref_loss_detect_enable_q <= wb_req_i.dat[0];
          held_ref_retention_q <= wb_req_i.dat[1];
          if (wb_req_i.dat[7:4] <= 4'h8) begin
            operation_mode_select_q <= wb_req_i.dat[7:4];
          end
          ride_through_select_q <= (wb_req_i.dat[9:8] == 2'h3) ?
            ride_through_select_q : wb_req_i.dat[9:8];
        end
        `DRSUP_ADR_SERIAL: begin
          station_q <= wb_req_i.dat[4:0];
          if (wb_req_i.dat[9:8] != 2'h3) begin
            baud_q <= wb_req_i.dat[9:8];
          end
          if (wb_req_i.dat[11:10] != 2'h3) begin
            parity_q <= wb_req_i.dat[11:10];
          end
          serial_freq_resolution_q <= wb_req_i.dat[13:12];
          serial_timeout_enable_q <= wb_req_i.dat[16];
          comm_error_response_q <= wb_req_i.dat[21:20];
        end
        `DRSUP_ADR_JOG: begin
          // jog reference up to 400.0 Hz
          if (wb_req_i.dat[11:0] <= `DRSUP_JOG_MAX) begin
            jog_reference_q <= wb_req_i.dat[11:0];
          end
        end
        `DRSUP_ADR_RIDE: begin
          if (wb_req_i.dat[4:0] <= `DRSUP_RIDE_T_MAX) begin
            ride_through_deactivation_time_q <= wb_req_i.dat[4:0];
          end
        end
        `DRSUP_ADR_MAXFREQ: begin
          max_output_frequency_q <= wb_req_i.dat[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  // serial link settings latched only at reset release
  logic boot_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_q <= 1'b1;
      station_act_q <= 5'h00;
      baud_act_q <= `DRSUP_BAUD_RST;
      parity_act_q <= `DRSUP_PARITY_RST;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        station_act_q <= station_q;
        baud_act_q <= baud_q;
        parity_act_q <= parity_q;
      end
    end
  end
  assign serial_station_address_o = station_act_q;
  assign serial_baud_select_o = baud_act_q;
  assign serial_parity_select_o = parity_act_q;

  // limit points in 0.1 Hz units
  wire logic [18:0] up_prod = max_output_frequency_q * ref_upper_limit_q;
  wire logic [18:0] lo_prod = max_output_frequency_q * ref_lower_limit_q;
  wire logic [12:0] upper_hz = 13'(up_prod / 19'd100);
  wire logic [12:0] lower_hz = 13'(lo_prod / 19'd100);

  logic run_q, serial_sel_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_sel_q <= 1'b0;
    end else if (!run_q) begin
      serial_sel_q <= term_s2_q.serial_sel;
    end
  end

  // serial mode for operation mode 4..8 or the latched serial select input
  wire logic serial_mode = serial_sel_q ||
    (operation_mode_select_q >= 4'h4 && operation_mode_select_q <= 4'h8);

  logic [11:0] serial_ref_q;
  logic serial_run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_ref_q <= 12'h000;
      serial_run_q <= 1'b0;
    end else if (serial_cmd_i.cmd_valid) begin
      serial_run_q <= serial_cmd_i.run;
      serial_ref_q <= (serial_freq_resolution_q == 2'h1) ?
        12'(serial_cmd_i.freq / 16'd10) : serial_cmd_i.freq[11:0];
    end
  end

  logic [31:0] to_cnt_q;
  logic comm_err_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_q <= '0;
    end else if (serial_cmd_i.cmd_valid || !serial_timeout_enable_q) begin
      to_cnt_q <= '0;
    end else if (to_cnt_q <= 32'(TIMEOUT_CYC)) begin
      to_cnt_q <= to_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comm_err_q <= 1'b0;
    end else if (serial_mode && serial_timeout_enable_q &&
                 to_cnt_q > 32'(TIMEOUT_CYC)) begin
      comm_err_q <= 1'b1;
    end else if (err_clr && wb_req_i.dat[0]) begin
      comm_err_q <= 1'b0;
    end
  end

  wire logic run_cmd = serial_mode ? serial_run_q : term_s2_q.run;
  wire logic jog_act = term_s2_q.jog && term_s2_q.run;
  logic [11:0] sel_ref, held_q;
  always_comb begin
    if (jog_act) begin
      sel_ref = jog_reference_q;
    end else if (serial_mode) begin
      sel_ref = serial_ref_q;
    end else if (term_s2_q.updown_hold) begin
      sel_ref = held_q;
    end else begin
      sel_ref = auto_ref_i;
    end
  end

  // held reference kept in preset one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_q <= 12'h000;
    end else if (!term_s2_q.updown_hold) begin
      held_q <= auto_ref_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preset_reference_one_q <= 12'h000;
    end else if (wb_wr && wb_req_i.adr == `DRSUP_ADR_PRESET1) begin
      preset_reference_one_q <= wb_req_i.dat[11:0];
    end else if (held_ref_retention_q && term_s2_q.updown_hold) begin
      preset_reference_one_q <= held_q;
    end
  end

  // reference-loss supervision
  drsup_loss_t loss_q;
  logic [31:0] win_cnt_q;
  logic [11:0] peak_q, hold_ref_q, out_q;
  wire logic [12:0] min_auto = 13'(max_output_frequency_q / 12'd20);
  // tenfold reference stays below 16 bits, unlike a hundredfold one
  wire logic fell90 = 16'(auto_ref_i) * 16'd10 <= 16'(peak_q);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loss_q <= DRSUP_LOSS_IDLE;
      win_cnt_q <= '0;
      peak_q <= 12'h000;
      hold_ref_q <= 12'h000;
    end else begin
      case (loss_q)
        DRSUP_LOSS_IDLE: begin
          if (ref_loss_detect_enable_q && !serial_mode &&
              13'(auto_ref_i) >= min_auto) begin
            loss_q <= DRSUP_LOSS_WATCH;
            peak_q <= auto_ref_i;
            win_cnt_q <= '0;
          end
        end
        DRSUP_LOSS_WATCH: begin
          // reference under 5 percent never supervised
          if (!ref_loss_detect_enable_q || 13'(auto_ref_i) < min_auto) begin
            loss_q <= DRSUP_LOSS_IDLE;
          // hold 80 percent on fast drop
          end else if (fell90 && win_cnt_q < 32'(LOSS_CYC)) begin
            loss_q <= DRSUP_LOSS_HOLD;
            hold_ref_q <= 12'((16'(out_q) * 16'd8) / 16'd10);
          // slow drop just restarts the window
          end else if (auto_ref_i >= peak_q ||
                       win_cnt_q >= 32'(LOSS_CYC)) begin
            peak_q <= auto_ref_i;
            win_cnt_q <= '0;
          end else begin
            win_cnt_q <= win_cnt_q + 32'h1;
          end
        end
        DRSUP_LOSS_HOLD: begin
          if (auto_ref_i > hold_ref_q || !run_cmd) begin
            loss_q <= DRSUP_LOSS_IDLE;
          end
        end
        default: begin
          loss_q <= DRSUP_LOSS_IDLE;
        end
      endcase
    end
  end

  logic [11:0] ref_pre;
  logic [11:0] ref_clamped;
  always_comb begin
    ref_pre = (loss_q == DRSUP_LOSS_HOLD && !jog_act) ? hold_ref_q : sel_ref;
    if (13'(ref_pre) > upper_hz) begin
      ref_clamped = upper_hz[11:0];
    end else if (13'(ref_pre) < lower_hz) begin
      ref_clamped = lower_hz[11:0];
    end else begin
      ref_clamped = ref_pre;
    end
  end

  logic [31:0] ride_cnt_q;
  logic [4:0] ride_tenths_q;
  logic pl_stop_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ride_cnt_q <= '0;
      ride_tenths_q <= 5'h00;
      pl_stop_q <= 1'b0;
    end else if (!term_s2_q.power_loss) begin
      ride_cnt_q <= '0;
      ride_tenths_q <= 5'h00;
      if (!run_cmd) begin
        pl_stop_q <= 1'b0;
      end
    end else begin
      case (ride_through_select_q)
        2'h1: begin
          if (ride_tenths_q >= ride_through_deactivation_time_q) begin
            pl_stop_q <= 1'b1;
          end else if (ride_cnt_q >= 32'(RIDE_STEP_CYC - 1)) begin
            ride_cnt_q <= '0;
            ride_tenths_q <= ride_tenths_q + 5'h01;
          end else begin
            ride_cnt_q <= ride_cnt_q + 32'h1;
          end
        end
        2'h2: begin
          pl_stop_q <= 1'b0;
        end
        default: begin
          pl_stop_q <= 1'b1;
        end
      endcase
    end
  end

  wire logic err_stop = comm_err_q && comm_error_response_q != 2'h3;
  wire logic run_d = run_cmd && !pl_stop_q && !err_stop;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      out_q <= 12'h000;
      drive_o <= '0;
    end else begin
      run_q <= run_d;
      out_q <= run_d ? ref_clamped : 12'h000;
      drive_o.run <= run_d;
      drive_o.freq <= run_d ? ref_clamped : 12'h000;
      drive_o.coast <= err_stop && comm_error_response_q == 2'h1;
      drive_o.decel2 <= err_stop && comm_error_response_q == 2'h2;
      drive_o.fault <= err_stop || pl_stop_q;
      drive_o.comm_alarm <= comm_err_q && comm_error_response_q == 2'h3;
      drive_o.undervoltage_alarm <= term_s2_q.power_loss &&
        ride_through_select_q == 2'h2;
    end
  end

  // register read-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= wb_hit;
      case (wb_req_i.adr)
        `DRSUP_ADR_LIMITS: rdata_q <= {16'h0, 1'b0, ref_lower_limit_q,
                                       1'b0, ref_upper_limit_q};
        `DRSUP_ADR_CONFIG: rdata_q <= {22'h0, ride_through_select_q,
          operation_mode_select_q, 2'h0, held_ref_retention_q,
          ref_loss_detect_enable_q};
        `DRSUP_ADR_SERIAL: rdata_q <= {10'h0, comm_error_response_q, 3'h0,
          serial_timeout_enable_q, 2'h0, serial_freq_resolution_q,
          parity_q, baud_q, 3'h0, station_q};
        `DRSUP_ADR_JOG: rdata_q <= {20'h0, jog_reference_q};
        `DRSUP_ADR_PRESET1: rdata_q <= {20'h0, preset_reference_one_q};
        `DRSUP_ADR_RIDE: rdata_q <= {27'h0, ride_through_deactivation_time_q};
        `DRSUP_ADR_STATUS: rdata_q <= {24'h0, loss_q, 1'b0, pl_stop_q,
          serial_mode, run_q, comm_err_q};
        `DRSUP_ADR_OUTFREQ: rdata_q <= {20'h0, out_q};
        `DRSUP_ADR_MAXFREQ: rdata_q <= {20'h0, max_output_frequency_q};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign wb_rsp_o = '{ack: ack_q, dat: rdata_q};
endmodule

/* verif/drsup_plc_model.sv */
`timescale 1ns/1ns
module drsup_plc_model (
  input wire logic clk_i,
  output drsup_pkg::drsup_serial_cmd_t cmd_o
);
  import drsup_pkg::*;
  initial cmd_o = '0;
  task automatic send(input logic run, input logic [15:0] f);
    @(posedge clk_i);
    cmd_o <= '{cmd_valid: 1'b1, run: run, freq: f};
    @(posedge clk_i);
    // released field must not look like a held value
    cmd_o <= '{cmd_valid: 1'b0, run: ~run, freq: ~f};
  endtask
endmodule

/* verif/drsup_chk.sv */
`timescale 1ns/1ns
module drsup_chk #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire drsup_pkg::drsup_wb_req_t wb_req_i,
  input wire drsup_pkg::drsup_wb_rsp_t wb_rsp_o,
  input wire drsup_pkg::drsup_term_t term_i,
  input wire drsup_pkg::drsup_serial_cmd_t serial_cmd_i,
  input wire drsup_pkg::drsup_drive_t drive_o,
  input wire logic [4:0] serial_station_address_o,
  input wire logic [1:0] serial_baud_select_o,
  input wire logic [1:0] serial_parity_select_o
);
  import drsup_pkg::*;
  int quiet_q;
  // silence since last message, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || serial_cmd_i.cmd_valid) begin
      quiet_q <= 0;
    end else if (quiet_q < TIMEOUT_CYC + 8) begin
      quiet_q <= quiet_q + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> drive_o == '0 && !wb_rsp_o.ack)
    else $error("outputs active after reset");
  a_link_frozen: assert property (
    !$past(rst_i) && !$past(rst_i, 2) |-> $stable({serial_station_address_o,
    serial_baud_select_o, serial_parity_select_o}))
    else $error("link setting changed while running");
  a_link_legal: assert property (
    serial_baud_select_o != 2'h3 && serial_parity_select_o != 2'h3)
    else $error("illegal baud or parity code");
  a_uv_cause: assert property (
    $rose(drive_o.undervoltage_alarm) |-> $past(term_i.power_loss, 3))
    else $error("undervoltage alarm without power loss");
  a_uv_no_fault: assert property (
    drive_o.undervoltage_alarm && !$past(drive_o.fault) |-> !drive_o.fault)
    else $error("fault raised during indefinite ride-through");
  a_timeout_late: assert property (
    $rose(drive_o.comm_alarm) |-> quiet_q >= TIMEOUT_CYC - 2)
    else $error("comm alarm before timeout elapsed");
endmodule
bind drsup_top drsup_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o),
  .term_i(term_i),
  .serial_cmd_i(serial_cmd_i),
  .drive_o(drive_o),
  .serial_station_address_o(serial_station_address_o),
  .serial_baud_select_o(serial_baud_select_o),
  .serial_parity_select_o(serial_parity_select_o)
);

/* verif/tb_top.sv */
`timescale 1ns/1ns
`include "drsup_regs.svh"
module tb_top;
  import drsup_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  drsup_wb_req_t req = '0;
  drsup_wb_rsp_t rsp;
  drsup_term_t term = '0;
  logic [11:0] aref = 12'h000;
  drsup_serial_cmd_t scmd;
  drsup_drive_t drv;
  logic [4:0] addr;
  logic [1:0] baud;
  logic [1:0] par;
  logic [31:0] rd;
  int failures = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  drsup_top #(.LOSS_CYC(40), .TIMEOUT_CYC(200), .RIDE_STEP_CYC(10)) uut (
    .clk_i(clk),
    .rst_i(rst),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .term_i(term),
    .auto_ref_i(aref),
    .serial_cmd_i(scmd),
    .drive_o(drv),
    .serial_station_address_o(addr),
    .serial_baud_select_o(baud),
    .serial_parity_select_o(par)
  );
  drsup_plc_model plc (.clk_i(clk), .cmd_o(scmd));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rsp.ack === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      complete_run();
    end
    rd = rsp.dat;
    req <= '0;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    term <= '0;
    aref <= 12'h000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_regs();
    wb(1'b0, `DRSUP_ADR_LIMITS, 32'h0);
    check(rd, 32'h0000_0064);
    wb(1'b0, `DRSUP_ADR_CONFIG, 32'h0);
    check(rd, 32'h0000_0030);
    wb(1'b0, `DRSUP_ADR_MAXFREQ, 32'h0);
    check(rd, 32'h0000_0258);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, `DRSUP_ADR_LIMITS, 32'h0000_646D);
    wb(1'b0, `DRSUP_ADR_LIMITS, 32'h0);
    check(rd, 32'h0000_646D);
    wb(1'b1, `DRSUP_ADR_LIMITS, 32'h0000_006E);
    wb(1'b0, `DRSUP_ADR_LIMITS, 32'h0);
    check(rd, 32'h0000_006D);
    check({addr, baud, par}, {5'h00, 2'h2, 2'h1});
    wb(1'b1, `DRSUP_ADR_SERIAL, 32'h0011_0805);
    repeat (4) @(posedge clk);
    check({addr, baud, par}, {5'h00, 2'h2, 2'h1});
    wb(1'b0, `DRSUP_ADR_SERIAL, 32'h0);
    check(rd, 32'h0011_0805);
    $display("t_regs done");
  endtask
  task automatic t_clamp();
    wb(1'b1, `DRSUP_ADR_LIMITS, 32'h0000_0A50);
    wb(1'b1, `DRSUP_ADR_JOG, 32'h0000_00C8);
    term.run <= 1'b1;
    aref <= 12'h2BC;
    repeat (8) @(posedge clk);
    check(drv.freq, 12'h1E0);
    aref <= 12'h014;
    repeat (8) @(posedge clk);
    check(drv.freq, 12'h03C);
    term.jog <= 1'b1;
    repeat (8) @(posedge clk);
    check(drv.freq, 12'h0C8);
    wb(1'b1, `DRSUP_ADR_JOG, 32'h0000_0FA1);
    wb(1'b0, `DRSUP_ADR_JOG, 32'h0);
    check(rd, 32'h0000_00C8);
    term.jog <= 1'b0;
    wb(1'b1, `DRSUP_ADR_CONFIG, 32'h0000_0032);
    aref <= 12'h100;
    repeat (8) @(posedge clk);
    term.updown_hold <= 1'b1;
    repeat (8) @(posedge clk);
    aref <= 12'h1A0;
    repeat (8) @(posedge clk);
    check(drv.freq, 12'h100);
    wb(1'b0, `DRSUP_ADR_PRESET1, 32'h0);
    check(rd, 32'h0000_0100);
    $display("t_clamp done");
  endtask
  task automatic t_serial();
    do_reset();
    term.run <= 1'b1;
    aref <= 12'h064;
    repeat (8) @(posedge clk);
    term.serial_sel <= 1'b1;
    repeat (8) @(posedge clk);
    check({drv.run, drv.freq}, {1'b1, 12'h064});
    term.run <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, `DRSUP_ADR_STATUS, 32'h0);
    check(rd[2], 1'b1);
    term.serial_sel <= 1'b0;
    wb(1'b1, `DRSUP_ADR_CONFIG, 32'h0000_0040);
    plc.send(1'b1, 16'h0159);
    repeat (4) @(posedge clk);
    check({drv.run, drv.freq}, {1'b1, 12'h159});
    wb(1'b1, `DRSUP_ADR_SERIAL, 32'h0011_1600);
    plc.send(1'b1, 16'h0D80);
    repeat (4) @(posedge clk);
    check(drv.freq, 12'h159);
    $display("t_serial done");
  endtask
  task automatic t_timeout();
    logic [4:0] ex [5] = '{5'h10, 5'h18, 5'h14, 5'h03, 5'h01};
    for (int r = 0; r < 5; r++) begin
      do_reset();
      wb(1'b1, `DRSUP_ADR_CONFIG, 32'h0000_0040);
      wb(1'b1, `DRSUP_ADR_SERIAL,
         {10'h0, 2'(r), 3'h0, 1'(r < 4), 16'h0600});
      plc.send(1'b1, 16'h0159);
      repeat (230) @(posedge clk);
      check({drv.fault, drv.coast, drv.decel2, drv.comm_alarm, drv.run},
            ex[r]);
      wb(1'b0, `DRSUP_ADR_STATUS, 32'h0);
      check(rd[0], r < 4);
    end
    $display("t_timeout done");
  endtask
  task automatic t_ride();
    logic [2:0] ex [3] = '{3'h2, 3'h2, 3'h5};
    for (int m = 0; m < 3; m++) begin
      do_reset();
      wb(1'b1, `DRSUP_ADR_RIDE, 32'h0000_0005);
      wb(1'b1, `DRSUP_ADR_CONFIG, {22'h0, 2'(m), 8'h30});
      term.run <= 1'b1;
      aref <= 12'h12C;
      repeat (8) @(posedge clk);
      term.power_loss <= 1'b1;
      repeat (30) @(posedge clk);
      check(drv.run, m != 0);
      repeat (40) @(posedge clk);
      check({drv.run, drv.fault, drv.undervoltage_alarm}, ex[m]);
    end
    $display("t_ride done");
  endtask
  task automatic t_loss();
    do_reset();
    term.run <= 1'b1;
    aref <= 12'h1F4;
    repeat (10) @(posedge clk);
    aref <= 12'h028;
    repeat (10) @(posedge clk);
    check(drv.freq, 12'h028);
    wb(1'b1, `DRSUP_ADR_CONFIG, 32'h0000_0031);
    aref <= 12'h1F4;
    repeat (50) @(posedge clk);
    aref <= 12'h028;
    repeat (10) @(posedge clk);
    check(drv.freq, 12'h190);
    wb(1'b0, `DRSUP_ADR_STATUS, 32'h0);
    check(rd[7:5], 3'h4);
    aref <= 12'h1C2;
    repeat (10) @(posedge clk);
    check(drv.freq, 12'h1C2);
    // slow fall over several windows: no hold
    for (int s = 8; s >= 0; s--) begin
      aref <= 12'(40 + 50 * s);
      repeat (10) @(posedge clk);
    end
    check(drv.freq, 12'h028);
    aref <= 12'h014;
    repeat (10) @(posedge clk);
    check(drv.freq, 12'h014);
    $display("t_loss done");
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    do_reset();
    t_regs();
    t_clamp();
    t_serial();
    t_timeout();
    t_ride();
    t_loss();
    complete_run();
  end
endmodule
